/* File: sbcf_pkg.sv */
// package: register map, field layout and timing constants for the config block
package sbcf_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    // config register field positions
    localparam int BIT_ENABLE     = 7;
    localparam int BIT_INHIBIT    = 6;
    localparam int BIT_BUSY       = 5;
    localparam int BIT_SDA_HOLD_EXTENSION_ENABLE    = 4;
    localparam int BIT_SCL_TO     = 3;
    localparam int BIT_FREE_TO    = 2;
    localparam int BIT_CS_HI      = 1;
    localparam int BIT_CS_LO      = 0;
    // writable bits of the config register (busy is read only)
    localparam logic [7:0] CONFIG_WMASK = 8'hDF;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // clock source codes
    localparam logic [1:0] CS_TIMER0 = 2'h0;
    localparam logic [1:0] CS_TIMER1 = 2'h1;
    // bus-free threshold in source periods (more than this many)
    localparam int FREE_PERIODS = 10;
    localparam int FREE_CNT_W   = 4;
    // ahb transfer type code for a nonsequential transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // bus line pair as carried through the synchronisers
    typedef struct packed {
        logic scl;
        logic sda;
    } sbcf_lines_t;

    // timer 3 control produced by the block
    typedef struct packed {
        logic reload_high;
        logic reload_low;
    } sbcf_t3ctl_t;
endpackage : sbcf_pkg

/* File: sbcf_sync.sv */
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module sbcf_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;   // first stage, read only by q

    // two stages; lines idle high, so reset high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q    <= INIT;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sbcf_sync

/* File: sbcf_top.sv */
// bus configuration, busy tracking and timeout support for a two-wire bus
//
// Summary of operation
// - slave inhibit blocks slave event interrupts
// - master event interrupts unaffected by inhibit
// - busy set while transfer in progress
// - busy cleared on stop or free timeout
// - hold extension selects normal or extended timing
// - scl timeout: timer3 reloads high, counts low
// - split mode: only high byte reloaded
// - bus free after 10+ source periods high
// - enable bit turns on line monitoring
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module sbcf_top
    import sbcf_pkg::*;
#(
    parameter int FREE_N = FREE_PERIODS
) (
    // clock, reset, enable
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // bus lines, asynchronous
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    // timer overflow pulses and timer 3 split mode from the timer block
    input  wire logic        T0_OVF,
    input  wire logic        T1_OVF,
    input  wire logic        T2_OVF,
    input  wire logic        T3_SPLIT,
    // engine events and interrupt requests
    input  wire logic        SLAVE_EVENT,
    input  wire logic        MASTER_EVENT,
    output logic             BUS_IRQ,
    // controls toward engine and timer 3
    output sbcf_t3ctl_t      T3_CTL,
    output logic             EXT_HOLD,
    output logic             BITRATE_TICK,
    output logic             START_SEEN,
    output logic             STOP_SEEN,
    output logic             BUS_BUSY
);
    logic [7:0]   config_reg;    // writable config bits
    logic         busy;          // transfer in progress
    sbcf_lines_t  lines_raw;     // pins before sync
    sbcf_lines_t  lines;         // synchronised lines
    sbcf_lines_t  lines_d;       // previous sample
    logic [FREE_CNT_W-1:0] free_cnt;   // high periods counted
    logic         free_timeout;  // bus free pulse
    // ahb data-phase capture
    logic         dp_write;
    logic         dp_read;
    logic [7:0]   dp_addr;

    // decoded config fields
    wire logic       enable    = config_reg[BIT_ENABLE];
    wire logic       inhibit   = config_reg[BIT_INHIBIT];
    wire logic       scl_to_en = config_reg[BIT_SCL_TO];
    wire logic       free_en   = config_reg[BIT_FREE_TO];
    wire logic [1:0] cs_sel    = config_reg[BIT_CS_HI:BIT_CS_LO];

    // two-flop sync of the pins
    assign lines_raw.scl = SCL_IN;
    assign lines_raw.sda = SDA_IN;
    sbcf_sync #(.WIDTH(2), .INIT(2'h3)) u_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .ce    (CE),
        .d     (lines_raw),
        .q     (lines)
    );

    // start: sda falls with scl high; stop: sda rises with scl high
    wire logic start_det = enable & lines.scl & lines_d.scl
                         & lines_d.sda & ~lines.sda;
    wire logic stop_det  = enable & lines.scl & lines_d.scl
                         & ~lines_d.sda & lines.sda;

    // clock source mux, remaining codes take timer 2
    function automatic logic pick_src(input logic [1:0] sel,
                                      input logic a, input logic b,
                                      input logic c);
        case (sel)
            CS_TIMER0: pick_src = a;
            CS_TIMER1: pick_src = b;
            default:   pick_src = c;
        endcase
    endfunction : pick_src
    wire logic src_tick = pick_src(cs_sel, T0_OVF, T1_OVF, T2_OVF);

    // both lines high, counted in source periods
    wire logic lines_high = lines.scl & lines.sda;
    wire logic free_hit   = free_en & enable & lines_high & src_tick
                          & (free_cnt == FREE_CNT_W'(FREE_N));

    // ahb address phase take and data phase config write decode
    wire logic ahb_take = HSEL & HREADY & HTRANS[1];
    wire logic wr_cfg   = dp_write & (dp_addr == ADDR_CONFIG);

    // sample previous line state for edge finding
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            lines_d <= '1;
        end else if (CE) begin
            lines_d <= lines;
        end
    end

    // free-period counter; a low on either line restarts it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            free_cnt     <= '0;
            free_timeout <= 1'b0;
        end else if (CE) begin
            free_timeout <= free_hit;
            if (!lines_high || !free_en || !enable || free_hit) begin
                free_cnt <= '0;
            end else if (src_tick) begin
                // counting past 10 periods means "more than 10"
                free_cnt <= free_cnt + 1'b1;
            end
        end
    end

    // busy tracking; a start wins over a same-cycle timeout
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            busy <= 1'b0;
        end else if (CE) begin
            if (!enable) begin
                busy <= 1'b0;
            end else if (start_det) begin
                busy <= 1'b1;
            end else if (stop_det || free_timeout) begin
                busy <= 1'b0;
            end
        end
    end

    // ahb data phase capture; slave is zero wait state
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= '0;
        end else if (CE) begin
            dp_write <= ahb_take & HWRITE;
            dp_read  <= ahb_take & ~HWRITE;
            if (ahb_take) begin
                dp_addr <= HADDR;
            end
        end
    end

    // config register; busy bit is not stored here
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            config_reg <= CONFIG_RESET;
        end else if (CE && wr_cfg) begin
            config_reg <= HWDATA[7:0] & CONFIG_WMASK;
        end
    end

    // read mux; unmapped offsets read zero with okay
    wire logic [7:0] cfg_view = config_reg | (8'(busy) << BIT_BUSY);
    wire logic [31:0] rd_mux =
        (dp_addr == ADDR_CONFIG) ? {24'h000000, cfg_view} :
        (dp_addr == ADDR_STATUS) ?
            {28'h0000000, lines_high, free_timeout, lines.sda, lines.scl} :
            32'h00000000;

    // registered read data, loaded every cycle: from HADDR when a read address phase is taken, else from dp_addr
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA    <= '0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else if (CE) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            HRDATA    <= (ahb_take && !HWRITE) ?
                         ((HADDR == ADDR_CONFIG) ?
                          {24'h000000, cfg_view} :
                          (HADDR == ADDR_STATUS) ?
                          {28'h0000000, lines_high, free_timeout,
                           lines.sda, lines.scl} : 32'h00000000) : rd_mux;
        end
    end

    // interrupt gating; inhibit only masks slave events
    wire logic next_irq = enable & ((SLAVE_EVENT & ~inhibit)
                                    | MASTER_EVENT);

    // timer 3 reload: whole timer, or high byte only in split mode
    wire logic t3_hold = enable & scl_to_en & lines.scl;
    sbcf_t3ctl_t next_t3;
    assign next_t3.reload_high = t3_hold;
    assign next_t3.reload_low  = t3_hold & ~T3_SPLIT;

    // all outputs registered
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_IRQ      <= 1'b0;
            T3_CTL       <= '0;
            EXT_HOLD     <= 1'b0;
            BITRATE_TICK <= 1'b0;
            START_SEEN   <= 1'b0;
            STOP_SEEN    <= 1'b0;
            BUS_BUSY     <= 1'b0;
        end else if (CE) begin
            BUS_IRQ      <= next_irq;
            T3_CTL       <= next_t3;
            EXT_HOLD     <= config_reg[BIT_SDA_HOLD_EXTENSION_ENABLE];
            BITRATE_TICK <= enable & src_tick;
            START_SEEN   <= start_det;
            STOP_SEEN    <= stop_det;
            BUS_BUSY     <= busy;
        end
    end
endmodule : sbcf_top

/* File: sbcf_properties.sv */
// checker: port relations of the config block
`timescale 1ns/1ps
module sbcf_properties
    import sbcf_pkg::*;
#(
    parameter int FREE_N = FREE_PERIODS
) (
    // clock, reset, ahb
    input wire logic        CLOCK, RST_N, CE, HSEL, HWRITE, HREADY,
    input wire logic [7:0]  HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic [31:0] HWDATA,
    // lines, timers, events
    input wire logic        SCL_IN, T0_OVF, T1_OVF, T2_OVF, T3_SPLIT,
    input wire logic        SLAVE_EVENT, MASTER_EVENT,
    // outputs watched
    input wire logic        BUS_IRQ, EXT_HOLD, BITRATE_TICK,
    input wire logic        START_SEEN, STOP_SEEN, BUS_BUSY,
    input wire sbcf_pkg::sbcf_t3ctl_t T3_CTL
);
    logic [7:0] cfg;  // shadow of the config register
    logic       wp;   // write data phase pending
    logic       s1;   // scl sync stage one
    logic       s2;   // scl sync stage two
    // selected overflow source
    wire logic  tk = cfg[1] ? T2_OVF : (cfg[0] ? T1_OVF : T0_OVF);
    // shadow follows writes; sync mirrors the two-flop path
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cfg <= 8'h00;
            wp  <= 1'b0;
            s1  <= 1'b1;
            s2  <= 1'b1;
        end else if (CE) begin
            wp <= HSEL && HREADY && HTRANS[1] && HWRITE
                  && HADDR == ADDR_CONFIG;
            if (wp) cfg <= HWDATA[7:0] & CONFIG_WMASK;
            s1 <= SCL_IN;
            s2 <= s1;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    property p_inh;
        CE && cfg[7] && SLAVE_EVENT && !MASTER_EVENT
        |=> BUS_IRQ == !$past(cfg[6]);
    endproperty
    a_inh: assert property (p_inh)
        else $error("slave irq ignores inhibit");
    property p_mst;
        CE && cfg[7] && MASTER_EVENT |=> BUS_IRQ;
    endproperty
    a_mst: assert property (p_mst)
        else $error("master irq lost");
    property p_off;
        CE && !cfg[7] |=> !BUS_IRQ;
    endproperty
    a_off: assert property (p_off)
        else $error("irq while disabled");
    property p_start;
        START_SEEN |=> BUS_BUSY;
    endproperty
    a_start: assert property (p_start)
        else $error("busy not set on start");
    property p_stop;
        STOP_SEEN && !START_SEEN |=> !BUS_BUSY;
    endproperty
    a_stop: assert property (p_stop)
        else $error("busy not cleared on stop");
    property p_hold;
        CE |=> EXT_HOLD == $past(cfg[4]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold extension mismatch");
    property p_rhi;
        CE |=> T3_CTL.reload_high == $past(cfg[7] && cfg[3] && s2);
    endproperty
    a_rhi: assert property (p_rhi)
        else $error("timer high reload mismatch");
    property p_rlo;
        CE |=> T3_CTL.reload_low
            == $past(cfg[7] && cfg[3] && s2 && !T3_SPLIT);
    endproperty
    a_rlo: assert property (p_rlo)
        else $error("timer low reload mismatch");
    property p_tick;
        CE |=> BITRATE_TICK == $past(cfg[7] && tk);
    endproperty
    a_tick: assert property (p_tick)
        else $error("bit rate source mismatch");
endmodule : sbcf_properties

bind sbcf_top sbcf_properties #(.FREE_N(FREE_N)) u_props (.*);

/* File: sbcf_bus_peer.sv */
// bus peer: another master on the pulled-up two-wire bus
`timescale 1ns/1ps
module sbcf_bus_peer (
    // line levels at the block's pins
    output logic scl,
    output logic sda
);
    // released lines sit high through the pull-ups
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // start: sda falls while scl high; scl falls 80 ns later
    task automatic start();
        sda = 1'b0;
        #80 scl = 1'b0;
        #80;
    endtask : start
    // both lines back high with no stop: sda rises while scl low
    task automatic idle_hi();
        sda = 1'b1;
        #80 scl = 1'b1;
        #80;
    endtask : idle_hi
    // stop: sda rises while scl high
    task automatic stop();
        sda = 1'b0;
        #80 scl = 1'b1;
        #80 sda = 1'b1;
        #80;
    endtask : stop
endmodule : sbcf_bus_peer

/* File: sbcf_top_bench.sv */
// self-checking bench for the config and timeout block
`timescale 1ns/1ps
module sbcf_top_bench;
    import sbcf_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, rv;
    logic        t0 = 1'b0, t1 = 1'b0, t2 = 1'b0, split = 1'b0;
    logic        sev = 1'b0, mev = 1'b0;
    wire logic   scl, sda, hready, irq, ext, tick, sst, sstp, busy, hresp;
    wire logic [31:0] hrdata;
    sbcf_t3ctl_t t3;
    int          error_cnt = 0, check_count = 0;
    always #5 clock = ~clock;
    sbcf_bus_peer peer (.scl(scl), .sda(sda));
    // free timeout shortened to 2 so it fires on the third tick
    sbcf_top #(.FREE_N(2)) dut (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .SCL_IN(scl), .SDA_IN(sda),
        .T0_OVF(t0), .T1_OVF(t1), .T2_OVF(t2), .T3_SPLIT(split),
        .SLAVE_EVENT(sev), .MASTER_EVENT(mev), .BUS_IRQ(irq), .T3_CTL(t3),
        .EXT_HOLD(ext), .BITRATE_TICK(tick), .START_SEEN(sst),
        .STOP_SEEN(sstp), .BUS_BUSY(busy));
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // bounded wait for hready at an edge
    task automatic wrdy();
        for (int n = 0; n < 20; n++) begin
            @(posedge clock);
            if (hready === 1'b1) return;
        end
        error_cnt++;
        conclude();
    endtask : wrdy
    // one single word transfer; read data taken at the data edge
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
        rv = hrdata;
    endtask : ahb
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tk
    task automatic pulse(input logic [2:0] ov, input logic s, m);
        @(posedge clock);
        {t2, t1, t0} <= ov;
        {sev, mev} <= {s, m};
        @(posedge clock);
        {t2, t1, t0} <= 3'h0;
        {sev, mev} <= 2'h0;
        #1;
    endtask : pulse
    task automatic t_reg();
        ahb(1'b0, ADDR_CONFIG, 32'h0);
        chk("cfg reset", rv, 32'h00);
        chk("hresp okay", hresp, 1'b0);
        ahb(1'b1, ADDR_CONFIG, 32'hFF);
        tk(1);
        chk("ext hold on", ext, 1'b1);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status idle", rv, 32'hB);
        ahb(1'b0, ADDR_CONFIG, 32'h0);
        chk("busy read only", rv, 32'hDF);
        ahb(1'b1, 8'h08, 32'hFF);
        ahb(1'b0, 8'h08, 32'h0);
        chk("unmapped", rv, 32'h0);
        ahb(1'b1, ADDR_CONFIG, 32'h00);
        tk(1);
        chk("ext hold off", ext, 1'b0);
        $display("t_reg done");
    endtask : t_reg
    task automatic irq_case(input logic [7:0] c, input logic s, m, e);
        ahb(1'b1, ADDR_CONFIG, {24'h0, c});
        pulse(3'h0, s, m);
        chk("bus irq", irq, e);
    endtask : irq_case
    task automatic t_irq();
        irq_case(8'hC0, 1'b1, 1'b0, 1'b0);
        irq_case(8'hC0, 1'b0, 1'b1, 1'b1);
        irq_case(8'h80, 1'b1, 1'b0, 1'b1);
        irq_case(8'h40, 1'b0, 1'b1, 1'b0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_cs();
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, ADDR_CONFIG, 32'h80 | c);
            for (int k = 0; k < 3; k++) begin
                pulse(3'h1 << k, 1'b0, 1'b0);
                chk("tick", tick, k == (c > 1 ? 2 : c));
            end
        end
        ahb(1'b1, ADDR_CONFIG, 32'h00);
        pulse(3'h1, 1'b0, 1'b0);
        chk("tick off", tick, 1'b0);
        $display("t_cs done");
    endtask : t_cs
    task automatic t_busy();
        ahb(1'b1, ADDR_CONFIG, 32'h84);
        peer.start();
        tk(6);
        chk("busy on start", busy, 1'b1);
        peer.idle_hi();
        tk(4);
        pulse(3'h1, 1'b0, 1'b0);
        pulse(3'h1, 1'b0, 1'b0);
        tk(4);
        chk("busy two ticks", busy, 1'b1);
        pulse(3'h1, 1'b0, 1'b0);
        tk(4);
        chk("busy free", busy, 1'b0);
        peer.start();
        peer.stop();
        tk(6);
        chk("busy stop", busy, 1'b0);
        $display("t_busy done");
    endtask : t_busy
    task automatic t_t3();
        ahb(1'b1, ADDR_CONFIG, 32'h88);
        tk(2);
        chk("reload high", t3, 2'h3);
        @(posedge clock);
        split <= 1'b1;
        tk(2);
        chk("split reload", t3, 2'h2);
        peer.start();
        tk(5);
        chk("scl low count", t3, 2'h0);
        // timer 3 period of 25 ms lives in the timer block
        // its handler restarts the bus: enable off, then on again
        ahb(1'b1, ADDR_CONFIG, 32'h08);
        ahb(1'b1, ADDR_CONFIG, 32'h88);
        tk(2);
        chk("restart clears busy", busy, 1'b0);
        peer.stop();
        tk(5);
        chk("split high", t3, 2'h2);
        $display("t_t3 done");
    endtask : t_t3
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_reg();
        t_irq();
        t_cs();
        t_busy();
        t_t3();
        conclude();
    end
endmodule : sbcf_top_bench
